// *** common/dsf_pkg.sv ***
// Package for the device status flag bank: byte addresses, bit positions,
// reset values and timing constants.
// Assumes a 40 MHz reference clock.
package dsf_pkg;
	localparam logic [7:0] DSF_ADDR_SUMMARY   = 8'h01;
	localparam logic [7:0] DSF_ADDR_SUPPLY    = 8'h02;
	localparam logic [7:0] DSF_ADDR_MEMTEMP   = 8'h03;
	localparam logic [7:0] DSF_ADDR_LINK      = 8'h04;

	// Summary byte positions
	localparam int DSF_SUM_CHAN  = 7;
	localparam int DSF_SUM_LINK  = 5;
	localparam int DSF_SUM_MEM   = 4;
	localparam int DSF_SUM_SUP   = 3;
	localparam int DSF_SUM_TEST  = 2;
	localparam int DSF_SUM_RST   = 1;
	localparam int DSF_SUM_INIT  = 0;

	// Supply byte: usable bits, bit 4 reserved
	localparam logic [7:0] DSF_SUPPLY_MASK  = 8'hEF;
	// Memory/temperature byte positions
	localparam int DSF_MT_FOTP   = 7;
	localparam int DSF_MT_UOTP   = 6;
	localparam int DSF_MT_URW    = 5;
	localparam int DSF_MT_WACT   = 4;
	localparam int DSF_MT_TEMP   = 2;
	// Link byte positions
	localparam int DSF_LK_DOUT   = 7;
	localparam int DSF_LK_OSC    = 6;

	localparam logic [7:0] DSF_SUMMARY_RST  = 8'h03;
	localparam logic [7:0] DSF_ZERO_BYTE    = 8'h00;

	// Interface type codes
	localparam logic [2:0] DSF_IF_PSI_A     = 3'h1;
	localparam logic [2:0] DSF_IF_PSI_B     = 3'h5;
	localparam logic [2:0] DSF_IF_I2C_A     = 3'h6;
	localparam logic [2:0] DSF_IF_I2C_B     = 3'h7;

	localparam int DSF_CLK_MHZ          = 40;
	localparam int DSF_RECOVERY_US      = 1000;
	localparam int DSF_RECOVERY_CYCLES  = DSF_RECOVERY_US * DSF_CLK_MHZ;
	localparam int DSF_DATA_VALID_US    = 1000;
	localparam int DSF_DATA_VALID_CYCLES = DSF_DATA_VALID_US * DSF_CLK_MHZ;
	localparam int DSF_TIMER_W          = 20;

	typedef enum logic [1:0] {
		DSF_POL_REPORT,
		DSF_POL_SUPPRESS,
		DSF_POL_SILENT
	} dsf_policy_t;
endpackage : dsf_pkg

// *** verilog/dsf_down_timer.sv ***
// Reloadable down-counter that stops at zero.
// Assumes the reload level is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module dsf_down_timer
	import dsf_pkg::*;
#(
	parameter int W = DSF_TIMER_W
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         reload,
	input  wire logic [W-1:0] reload_val,
	output logic      [W-1:0] count_ff,
	output logic              zero_ff
);
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_ff <= '0;
		end else if (reload) begin
			count_ff <= reload_val;
		end else if (count_ff != '0) begin
			count_ff <= count_ff - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			zero_ff <= 1'b1;
		end else begin
			zero_ff <= !reload && (count_ff == '0 ||
				count_ff == W'(1));
		end
	end
endmodule : dsf_down_timer
`default_nettype wire

// *** verilog/dsf_status_bank.sv ***
// Device status flag bank: four read-only status bytes, summary flags,
// supply recovery timer and the response gating it drives.
// Assumes the host interfaces present read strobes and transmit reports
// as one-cycle pulses synchronous to ref_clk; sources are synchronous.
`timescale 1ns/1ps
`default_nettype none
module dsf_status_bank
	import dsf_pkg::*;
#(
	parameter int RECOVERY_CYCLES   = DSF_RECOVERY_CYCLES,
	parameter int DATA_VALID_CYCLES = DSF_DATA_VALID_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       rd_strobe,
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data_ff,
	input  wire logic       tx_report,
	input  wire logic [7:0] tx_summary_bits,
	input  wire logic [7:0] tx_supply_bits,
	input  wire logic [7:0] tx_memtemp_bits,
	input  wire logic       tx_done,
	input  wire logic [2:0] interface_type_select,
	input  wire logic       supply_fault_blocking_select,
	input  wire logic [3:0] channel_status,
	input  wire logic [7:0] supply_fault_in,
	input  wire logic       factory_otp_fault,
	input  wire logic       user_otp_fault,
	input  wire logic       rw_array_fault,
	input  wire logic       otp_write_busy,
	input  wire logic       temperature_fault,
	input  wire logic       dout_fault,
	input  wire logic       oscillator_training_fault,
	input  wire logic       test_mode_active,
	input  wire logic       test_mode_clear,
	input  wire logic [5:0] channel_user_config_1,
	input  wire logic [1:0] channel_user_config_3,
	output logic            response_allowed_ff,
	output logic            send_error_code_ff,
	output logic            supply_timer_zero_ff
);
	logic [7:0]             supply_ff;
	logic                   fotp_ff, uotp_ff, urw_ff, temp_ff;
	logic                   dout_ff, osc_ff, test_ff, rst_flag_ff, init_ff;
	logic                   err_pending_ff;
	logic [7:0]             cfg_ff;
	logic [DSF_TIMER_W-1:0] init_cnt_ff;
	logic [DSF_TIMER_W-1:0] rec_count;
	logic                   rec_zero;
	logic                   sup_any, chan_sum, link_sum, mem_sum;
	logic                   rd_sum, rd_sup, rd_mem;
	dsf_policy_t            policy;

	function automatic dsf_policy_t pick_policy(input logic [2:0] t,
		input logic blk);
		if (t == DSF_IF_I2C_A || t == DSF_IF_I2C_B) begin
			return DSF_POL_SILENT;
		end else if (t == DSF_IF_PSI_A || t == DSF_IF_PSI_B || blk) begin
			return DSF_POL_SUPPRESS;
		end else begin
			return DSF_POL_REPORT;
		end
	endfunction : pick_policy

	assign policy   = pick_policy(interface_type_select,
		supply_fault_blocking_select);
	assign sup_any  = |(supply_ff & DSF_SUPPLY_MASK);
	assign chan_sum = |channel_status;
	assign link_sum = dout_ff | osc_ff;
	assign mem_sum  = fotp_ff | uotp_ff | urw_ff |
		otp_write_busy | temp_ff;
	assign rd_sum   = rd_strobe && rd_addr == DSF_ADDR_SUMMARY;
	assign rd_sup   = rd_strobe && rd_addr == DSF_ADDR_SUPPLY;
	assign rd_mem   = rd_strobe && rd_addr == DSF_ADDR_MEMTEMP;

	////////////////////////////////////////////////////////////////////////
	// Supply faults and recovery timer

	dsf_down_timer #(
		.W          (DSF_TIMER_W)
	) dsf_down_timer_i (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.reload     (|(supply_fault_in & DSF_SUPPLY_MASK)),
		.reload_val (DSF_TIMER_W'(RECOVERY_CYCLES)),
		.count_ff   (rec_count),
		.zero_ff    (rec_zero)
	);

	// New faults win over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			supply_ff <= DSF_ZERO_BYTE;
		end else begin
			case (policy)
			DSF_POL_SUPPRESS: begin
				if (rec_zero && rec_count == '0) begin
					supply_ff <= supply_fault_in & DSF_SUPPLY_MASK;
				end else begin
					supply_ff <= (supply_ff | supply_fault_in) &
						DSF_SUPPLY_MASK;
				end
			end
			DSF_POL_SILENT: begin
				if (rd_sup && rec_zero) begin
					supply_ff <= supply_fault_in & DSF_SUPPLY_MASK;
				end else begin
					supply_ff <= (supply_ff | supply_fault_in) &
						DSF_SUPPLY_MASK;
				end
			end
			default: begin
				if (rec_zero && (rd_sup ||
					(tx_report && |tx_supply_bits))) begin
					supply_ff <= supply_fault_in & DSF_SUPPLY_MASK;
				end else begin
					supply_ff <= (supply_ff | supply_fault_in) &
						DSF_SUPPLY_MASK;
				end
			end
			endcase
		end
	end

	// One error-code response after expiry in report mode
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			err_pending_ff <= 1'b0;
		end else if (!rec_zero) begin
			err_pending_ff <= (policy == DSF_POL_REPORT);
		end else if (tx_done) begin
			err_pending_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			response_allowed_ff  <= 1'b0;
			send_error_code_ff   <= 1'b0;
			supply_timer_zero_ff <= 1'b1;
		end else begin
			response_allowed_ff  <= rec_zero;
			send_error_code_ff   <= rec_zero && err_pending_ff &&
				!tx_done;
			supply_timer_zero_ff <= rec_zero;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory, temperature and link faults

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fotp_ff <= 1'b0;
			uotp_ff <= 1'b0;
		end else begin
			fotp_ff <= fotp_ff | factory_otp_fault;
			uotp_ff <= uotp_ff | user_otp_fault;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			urw_ff <= 1'b0;
		end else if (rw_array_fault) begin
			urw_ff <= 1'b1;
		end else if (rd_mem || (tx_report &&
			tx_memtemp_bits[DSF_MT_URW])) begin
			urw_ff <= 1'b0;
		end
	end

	// Temperature and link faults are level reports from their monitors
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			temp_ff <= 1'b0;
			dout_ff <= 1'b0;
			osc_ff  <= 1'b0;
		end else begin
			temp_ff <= temperature_fault;
			dout_ff <= dout_fault;
			osc_ff  <= oscillator_training_fault;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Test, reset and initialisation flags

	// Test mode only leaves through a test operation; rst_n is no power cycle
	always_ff @(posedge ref_clk) begin
		if (test_mode_active) begin
			test_ff <= 1'b1;
		end else if (test_mode_clear) begin
			test_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rst_flag_ff <= 1'b1;
		end else if (rd_sum || (tx_report &&
			tx_summary_bits[DSF_SUM_RST])) begin
			rst_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cfg_ff <= DSF_ZERO_BYTE;
		end else begin
			cfg_ff <= {channel_user_config_1, channel_user_config_3};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			init_ff     <= 1'b1;
			init_cnt_ff <= DSF_TIMER_W'(DATA_VALID_CYCLES);
		end else if (cfg_ff != {channel_user_config_1,
			channel_user_config_3}) begin
			init_ff     <= 1'b1;
			init_cnt_ff <= DSF_TIMER_W'(DATA_VALID_CYCLES);
		end else if (init_cnt_ff != '0) begin
			init_cnt_ff <= init_cnt_ff - 1'b1;
		end else begin
			init_ff     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port; no write path exists

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_data_ff <= DSF_ZERO_BYTE;
		end else if (rd_strobe) begin
			if (rd_addr == DSF_ADDR_SUMMARY) begin
				rd_data_ff <= DSF_ZERO_BYTE;
				rd_data_ff[DSF_SUM_CHAN] <= chan_sum;
				rd_data_ff[DSF_SUM_LINK] <= link_sum;
				rd_data_ff[DSF_SUM_MEM]  <= mem_sum;
				rd_data_ff[DSF_SUM_SUP]  <= sup_any;
				rd_data_ff[DSF_SUM_TEST] <= test_ff;
				rd_data_ff[DSF_SUM_RST]  <= rst_flag_ff;
				rd_data_ff[DSF_SUM_INIT] <= init_ff;
			end else if (rd_addr == DSF_ADDR_SUPPLY) begin
				rd_data_ff <= supply_ff & DSF_SUPPLY_MASK;
			end else if (rd_addr == DSF_ADDR_MEMTEMP) begin
				rd_data_ff <= DSF_ZERO_BYTE;
				rd_data_ff[DSF_MT_FOTP] <= fotp_ff;
				rd_data_ff[DSF_MT_UOTP] <= uotp_ff;
				rd_data_ff[DSF_MT_URW]  <= urw_ff;
				rd_data_ff[DSF_MT_WACT] <= otp_write_busy;
				rd_data_ff[DSF_MT_TEMP] <= temp_ff;
			end else if (rd_addr == DSF_ADDR_LINK) begin
				rd_data_ff <= DSF_ZERO_BYTE;
				rd_data_ff[DSF_LK_DOUT] <= dout_ff;
				rd_data_ff[DSF_LK_OSC]  <= osc_ff;
			end else begin
				rd_data_ff <= DSF_ZERO_BYTE;
			end
		end
	end
endmodule : dsf_status_bank
`default_nettype wire

// *** verification/dsf_host_model.sv ***
// Host controller model: issues status byte reads to the bank.
// Assumes the bank answers one cycle after the strobe edge.
`timescale 1ns/1ps
`default_nettype none
module dsf_host_model (
	input  wire logic       ref_clk,
	output logic            rd_strobe,
	output logic      [7:0] rd_addr,
	input  wire logic [7:0] rd_data_ff
);
	initial begin
		rd_strobe = 1'b0;
		rd_addr   = 8'hFF;
	end
	// One-edge strobe, data taken a cycle later
	task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		rd_strobe = 1'b1;
		rd_addr   = a;
		@(negedge ref_clk);
		rd_strobe = 1'b0;
		// Released address is scrambled so nothing relies on it
		rd_addr   = ~a;
		d         = rd_data_ff;
	endtask : read_byte
endmodule : dsf_host_model
`default_nettype wire

// *** verification/dsf_status_bank_chk.sv ***
// Checker for the status bank: read answers and supply recovery gating.
// Assumes it is bound to every dsf_status_bank instance.
`timescale 1ns/1ps
`default_nettype none
module dsf_status_bank_chk
	import dsf_pkg::*;
#(
	parameter int RECOVERY_CYCLES   = DSF_RECOVERY_CYCLES,
	parameter int DATA_VALID_CYCLES = DSF_DATA_VALID_CYCLES
) (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       rd_strobe,
	input wire logic [7:0] rd_addr,
	input wire logic [7:0] rd_data_ff,
	input wire logic       tx_done,
	input wire logic [2:0] interface_type_select,
	input wire logic       supply_fault_blocking_select,
	input wire logic [3:0] channel_status,
	input wire logic [7:0] supply_fault_in,
	input wire logic       response_allowed_ff,
	input wire logic       send_error_code_ff,
	input wire logic       supply_timer_zero_ff
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic sum_rd;
	assign sum_rd = rd_strobe && rd_addr == DSF_ADDR_SUMMARY;
	////////////////////////////////////////////////////////////////////////
	a_unmapped_zero: assert property (rd_strobe && (rd_addr == 8'h00 ||
		rd_addr > DSF_ADDR_LINK) |=> rd_data_ff == DSF_ZERO_BYTE)
		else $error("unmapped read not zero");
	a_read_hold: assert property (!rd_strobe |=> $stable(rd_data_ff))
		else $error("read data moved without strobe");
	a_chan_summary: assert property (sum_rd && channel_status != 4'h0 &&
		$past(channel_status) != 4'h0 |=> rd_data_ff[DSF_SUM_CHAN])
		else $error("channel summary missing");
	a_reserved_zero: assert property (sum_rd |=> !rd_data_ff[6])
		else $error("reserved summary bit set");
	a_timer_reload: assert property (|(supply_fault_in & DSF_SUPPLY_MASK)
		|-> ##[1:2] !supply_timer_zero_ff)
		else $error("timer not reloaded");
	a_timer_runs: assert property ($fell(supply_timer_zero_ff) |->
		!supply_timer_zero_ff [*6])
		else $error("recovery interval too short");
	a_silent_run: assert property (!supply_timer_zero_ff |->
		!response_allowed_ff)
		else $error("response allowed while timer runs");
	a_error_cause: assert property ($rose(send_error_code_ff) |->
		supply_timer_zero_ff && !supply_fault_blocking_select &&
		!(interface_type_select inside {3'h1, 3'h5, 3'h6, 3'h7}))
		else $error("error code in wrong mode");
	a_error_once: assert property (send_error_code_ff && tx_done |=>
		!send_error_code_ff)
		else $error("error code outlived its response");
endmodule : dsf_status_bank_chk
bind dsf_status_bank dsf_status_bank_chk #(
	.RECOVERY_CYCLES(RECOVERY_CYCLES),
	.DATA_VALID_CYCLES(DATA_VALID_CYCLES)
) dsf_status_bank_chk_i (.ref_clk, .rst_n, .rd_strobe, .rd_addr,
	.rd_data_ff, .tx_done, .interface_type_select,
	.supply_fault_blocking_select, .channel_status, .supply_fault_in,
	.response_allowed_ff, .send_error_code_ff, .supply_timer_zero_ff);
`default_nettype wire

// *** verification/tb_dsf_status_bank.sv ***
// Testbench for the status bank: flags, clears and supply recovery.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_dsf_status_bank import dsf_pkg::*;;
	localparam int RCV = 8;
	logic       ref_clk, rst_n, rd_strobe, tx_report, tx_done, blk;
	logic       test_mode_active, test_mode_clear, factory_otp_fault;
	logic       user_otp_fault, rw_array_fault, otp_write_busy, sup;
	logic       temperature_fault, dout_fault, oscillator_training_fault;
	logic       response_allowed_ff, send_error_code_ff, supply_timer_zero_ff;
	logic       rep;
	logic [7:0] rd_addr, rd_data_ff, tx_sum, supply_fault_in, d;
	logic [7:0] tx_sup, tx_mem;
	logic [3:0] channel_status;
	logic [2:0] itype;
	logic [5:0] channel_user_config_1;
	logic [1:0] channel_user_config_3;
	int         error_cnt, n_compared;
	dsf_status_bank #(.RECOVERY_CYCLES(RCV), .DATA_VALID_CYCLES(RCV))
	dsf_status_bank_i (.ref_clk, .rst_n, .rd_strobe, .rd_addr, .rd_data_ff,
		.tx_report, .tx_summary_bits(tx_sum), .tx_supply_bits(tx_sup),
		.tx_memtemp_bits(tx_mem), .tx_done, .interface_type_select(itype),
		.supply_fault_blocking_select(blk), .channel_status, .supply_fault_in,
		.factory_otp_fault, .user_otp_fault, .rw_array_fault, .otp_write_busy,
		.temperature_fault, .dout_fault, .oscillator_training_fault,
		.test_mode_active, .test_mode_clear, .channel_user_config_1,
		.channel_user_config_3, .response_allowed_ff, .send_error_code_ff,
		.supply_timer_zero_ff);
	dsf_host_model dsf_host_model_i (.ref_clk, .rd_strobe, .rd_addr,
		.rd_data_ff);
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		dsf_host_model_i.read_byte(a, d);
		chk($sformatf("byte %h", a), d, e);
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	task automatic pulse(ref logic s);
		tick(1);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic wait_zero();
		int i;
		for (i = 0; i < 40 && supply_timer_zero_ff !== 1'b1; i++) tick(1);
		if (i == 40) begin
			error_cnt++;
			print_verdict();
		end
	endtask : wait_zero
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, tx_report, tx_done, blk, test_mode_active} = '0;
		{factory_otp_fault, user_otp_fault, rw_array_fault} = '0;
		{otp_write_busy, temperature_fault, dout_fault} = '0;
		{oscillator_training_fault, tx_sum, supply_fault_in} = '0;
		{tx_sup, tx_mem} = '0;
		{channel_status, itype, channel_user_config_1} = '0;
		channel_user_config_3 = 2'h0;
		// Test flag has no reset, so define it through the clear input
		test_mode_clear = 1'b1;
		error_cnt = 0;
		n_compared = 0;
		tick(20);
		rst_n = 1'b1;
		test_mode_clear = 1'b0;
		rd(DSF_ADDR_SUMMARY, DSF_SUMMARY_RST);
		rd(DSF_ADDR_SUMMARY, 8'h01);
		tick(12);
		rd(DSF_ADDR_SUMMARY, 8'h00);
		rd(8'h05, 8'h00);
		for (int i = 0; i < 4; i++) begin
			channel_status = 4'h1 << i;
			rd(DSF_ADDR_SUMMARY, 8'h80);
		end
		channel_status = 4'h0;
		{dout_fault, oscillator_training_fault} = 2'b10;
		rd(DSF_ADDR_LINK, 8'h80);
		{dout_fault, oscillator_training_fault} = 2'b01;
		rd(DSF_ADDR_SUMMARY, 8'h20);
		oscillator_training_fault = 1'b0;
		temperature_fault = 1'b1;
		rd(DSF_ADDR_MEMTEMP, 8'h04);
		{temperature_fault, otp_write_busy} = 2'b01;
		rd(DSF_ADDR_SUMMARY, 8'h10);
		otp_write_busy = 1'b0;
		rd(DSF_ADDR_MEMTEMP, 8'h00);
		pulse(rw_array_fault);
		rd(DSF_ADDR_MEMTEMP, 8'h20);
		rd(DSF_ADDR_MEMTEMP, 8'h00);
		// A report without the array bit must leave it set
		pulse(rw_array_fault);
		pulse(tx_report);
		rd(DSF_ADDR_MEMTEMP, 8'h20);
		pulse(rw_array_fault);
		tx_mem = 8'h20;
		pulse(tx_report);
		tx_mem = 8'h00;
		rd(DSF_ADDR_MEMTEMP, 8'h00);
		test_mode_active = 1'b1;
		rd(DSF_ADDR_SUMMARY, 8'h04);
		test_mode_active = 1'b0;
		rd(DSF_ADDR_SUMMARY, 8'h04);
		pulse(test_mode_clear);
		rd(DSF_ADDR_SUMMARY, 8'h00);
		channel_user_config_1 = 6'h2A;
		rd(DSF_ADDR_SUMMARY, 8'h01);
		tick(12);
		channel_user_config_3 = 2'h1;
		rd(DSF_ADDR_SUMMARY, 8'h01);
		tick(12);
		$display("flag tests done");
		// Last pass repeats type 0 with blocking selected
		for (int k = 0; k < 9; k++) begin
			itype = k[2:0];
			blk = (k == 8);
			sup = blk || itype == 3'h1 || itype == 3'h5;
			rep = !sup && itype < 3'h6;
			supply_fault_in = 8'h80;
			tick(1);
			supply_fault_in = 8'h00;
			rd(DSF_ADDR_SUPPLY, 8'h80);
			rd(DSF_ADDR_SUMMARY, 8'h08);
			chk("allowed", response_allowed_ff, 1'b0);
			wait_zero();
			tick(2);
			chk("allowed", response_allowed_ff, 1'b1);
			chk("error code", send_error_code_ff, rep);
			rd(DSF_ADDR_SUPPLY, sup ? 8'h00 : 8'h80);
			rd(DSF_ADDR_SUPPLY, 8'h00);
			pulse(tx_done);
			tick(1);
			chk("error code", send_error_code_ff, 1'b0);
		end
		// Report type: a transmission clears supply faults only at zero
		blk = 1'b0;
		tx_sup = 8'h80;
		supply_fault_in = 8'h80;
		tick(1);
		supply_fault_in = 8'h00;
		pulse(tx_report);
		rd(DSF_ADDR_SUMMARY, 8'h08);
		wait_zero();
		pulse(tx_report);
		rd(DSF_ADDR_SUMMARY, 8'h00);
		pulse(tx_done);
		tx_sup = 8'h00;
		supply_fault_in = 8'h10;
		rd(DSF_ADDR_SUPPLY, 8'h00);
		supply_fault_in = 8'h00;
		$display("supply tests done");
		pulse(factory_otp_fault);
		pulse(user_otp_fault);
		rd(DSF_ADDR_MEMTEMP, 8'hC0);
		rd(DSF_ADDR_MEMTEMP, 8'hC0);
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(12);
		rd(DSF_ADDR_MEMTEMP, 8'h00);
		tx_sum = 8'h02;
		pulse(tx_report);
		rd(DSF_ADDR_SUMMARY, 8'h00);
		$display("clear tests done");
		print_verdict();
	end
endmodule : tb_dsf_status_bank
`default_nettype wire
